// ---- e3dm_defines.svh ----
// Register indices, field positions, reset values and counts
// Included by every design file of the E3 defect monitor except the package
`ifndef E3DM_DEFINES_SVH
`define E3DM_DEFINES_SVH

// ==========================================================
// Register indices, byte address is four times the index
`define E3DM_IDX_OPMODE     16'h1100
`define E3DM_IDX_DEFECT     16'h1111
`define E3DM_IDX_ISTAT      16'h1114
`define E3DM_IDX_MASK       16'h1115

// ==========================================================
// Reset values
`define E3DM_RST_OPMODE     8'h0b
`define E3DM_RST_LOF_ALGO   1'h0
`define E3DM_RST_ISTAT      7'h00
`define E3DM_RST_MASK       7'h7f

// ==========================================================
// Field positions
`define E3DM_OP_OWN_LOS     5
`define E3DM_OP_DS3         6
`define E3DM_DS_LOF_ALGO    7
`define E3DM_DS_LOS         4
`define E3DM_DS_AIS         3
`define E3DM_IS_AIS         0
`define E3DM_IS_LOS         1

// ==========================================================
// Counts in line bits and zeros, and the word transfer size
`define E3DM_LOS_RUN        32
`define E3DM_LOS_CLEAN_RUN  4
`define E3DM_AIS_MAX_ZEROS  7
`define E3DM_HSIZE_WORD     3'h2

`endif

// ---- e3dm_pkg.sv ----
// Types shared by the E3 defect monitor
// Assumes nothing beyond a SystemVerilog compiler
package e3dm_pkg;

    // ======================================================
    // Carriers
    typedef struct packed {
        logic bit_val;
        logic bit_en;
        logic frame_start;
        logic liu_los;
    } e3dm_line_t;

    typedef struct packed {
        logic lof;
        logic oof;
        logic payload_label_unstable;
        logic trail_trace_mismatch_flag;
        logic ferf;
    } e3dm_ext_def_t;

    typedef struct packed {
        logic msg_chg;
        logic oos_chg;
        logic frame_alignment_change;
        logic oof_chg;
        logic lof_chg;
    } e3dm_ext_evt_t;

    // ======================================================
    // States and selects
    typedef enum logic [1:0] {BUS_IDLE, BUS_WR, BUS_RD, BUS_RDONE}
        e3dm_bus_st_t;
    typedef enum logic [2:0] {SEL_NONE, SEL_OPMODE, SEL_DEFECT,
                              SEL_ISTAT, SEL_MASK} e3dm_sel_t;

endpackage

// ---- e3dm_los_det.sv ----
// Loss-of-signal detector on the received E3 bit stream
// Assumes one bit enable pulse per received bit on hclk
`include "e3dm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module e3dm_los_det import e3dm_pkg::*; #(
    parameter int RUN_LEN   = `E3DM_LOS_RUN,
    parameter int CLEAN_RUN = `E3DM_LOS_CLEAN_RUN
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire e3dm_line_t line_i,
    input  wire logic       own_on,
    output logic            los_defect
);
    localparam int CW = $clog2(RUN_LEN + 1);
    localparam logic [CW-1:0] RUN_MAX = CW'(RUN_LEN);
    localparam logic [CW-1:0] CLN_LIM = CW'(CLEAN_RUN - 1);

    logic [CW-1:0] zrun_r;
    logic [CW-1:0] zrun_nxt;
    logic [CW-1:0] clean_r;
    logic [CW-1:0] clean_nxt;
    logic          own_los_r;
    logic          own_los_nxt;

    // ======================================================
    // Zero run and clean window counters
    always_comb begin
        zrun_nxt  = zrun_r;
        clean_nxt = clean_r;
        if (line_i.bit_en) begin
            if (line_i.bit_val)
                zrun_nxt = '0;
            else if (zrun_r != RUN_MAX)
                zrun_nxt = zrun_r + 1'b1;
            if (!line_i.bit_val && zrun_r >= CLN_LIM)
                clean_nxt = '0;
            else if (clean_r != RUN_MAX)
                clean_nxt = clean_r + 1'b1;
        end
        own_los_nxt = own_los_r;
        if (!own_on)
            own_los_nxt = 1'b0;
        else if (zrun_nxt == RUN_MAX)
            own_los_nxt = 1'b1;
        else if (own_los_r && clean_nxt == RUN_MAX)
            own_los_nxt = 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zrun_r    <= '0;
            clean_r   <= '0;
            own_los_r <= 1'b0;
        end else begin
            zrun_r    <= zrun_nxt;
            clean_r   <= clean_nxt;
            own_los_r <= own_los_nxt;
        end
    end

    // Line unit loss forces the defect, clearance needs both
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            los_defect <= 1'b0;
        else
            los_defect <= own_los_nxt | line_i.liu_los;
    end

    // ======================================================
    // Checks
    los_declare_a: assert property (@(posedge hclk) disable iff (!hresetn)
        own_on && line_i.bit_en && !line_i.bit_val
        && zrun_r == RUN_MAX - 1'b1 |=> own_los_r && los_defect)
        else $error("zero run did not declare loss of signal");
    liu_los_a: assert property (@(posedge hclk) disable iff (!hresetn)
        line_i.liu_los |=> los_defect)
        else $error("line unit loss not reflected");
    own_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !own_on |=> !own_los_r)
        else $error("own detector active while disabled");
    los_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(own_los_r) && own_on |-> clean_r == RUN_MAX)
        else $error("loss cleared without a clean window");
endmodule
`default_nettype wire

// ---- e3dm_ais_det.sv ----
// Alarm indication detector, zeros counted over frame periods
// Assumes frame_start marks the first bit of each E3 frame
`include "e3dm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module e3dm_ais_det import e3dm_pkg::*; #(
    parameter int MAX_ZEROS = `E3DM_AIS_MAX_ZEROS
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire e3dm_line_t line_i,
    input  wire logic       e3_mode,
    output logic            ais_defect
);
    localparam logic [3:0] SAT = 4'(MAX_ZEROS + 1);
    localparam logic [4:0] LIM = 5'(MAX_ZEROS);

    logic [3:0] cur_r;
    logic [3:0] prev_r;
    logic [4:0] pair_sum;
    logic       zero_in;

    assign zero_in  = line_i.bit_en && !line_i.bit_val;
    assign pair_sum = {1'b0, cur_r} + {1'b0, prev_r};

    // ======================================================
    // Saturating zero count per frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cur_r  <= '0;
            prev_r <= SAT;
        end else if (line_i.frame_start) begin
            prev_r <= cur_r;
            cur_r  <= zero_in ? 4'h1 : 4'h0;
        end else if (zero_in && cur_r != SAT) begin
            cur_r  <= cur_r + 4'h1;
        end
    end

    // Declare on few zeros over two frames, clear on two busy frames
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            ais_defect <= 1'b0;
        else if (!e3_mode)
            ais_defect <= 1'b0;
        else if (line_i.frame_start) begin
            if (pair_sum <= LIM)
                ais_defect <= 1'b1;
            else if (cur_r == SAT && prev_r == SAT)
                ais_defect <= 1'b0;
        end
    end

    // ======================================================
    // Checks
    ais_declare_a: assert property (@(posedge hclk) disable iff (!hresetn)
        e3_mode && line_i.frame_start && pair_sum <= LIM |=> ais_defect)
        else $error("few zeros did not declare alarm indication");
    ais_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(ais_defect) && $past(e3_mode) |->
        $past(cur_r) == SAT && $past(prev_r) == SAT)
        else $error("alarm cleared without two busy frames");
endmodule
`default_nettype wire

// ---- e3dm_top.sv ----
// E3 receive LOS and AIS defect monitor with AHB-Lite registers
// Assumes one clock, line inputs synchronous to hclk
//
// Contract
// - LOS change sets flag bit 1, interrupt
// - Own detector off: LOS from line unit only
// - Own detector enable in operating mode register
// - AIS on seven or fewer zeros, two frames, with operating mode bit 6 low
// - AIS declared shows at defect status bit 3
// - AIS change sets flag bit 0, interrupt
// - Interrupt status bit 7 zero, others clear-on-read
// - Defect status bit 7 writable, rest read-only
// - LOS on 32 zeros or line unit
// - LOS clears after clean window and line clear
// - AIS clears after two frames of eight zeros
`include "e3dm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module e3dm_top import e3dm_pkg::*; #(
    parameter int LOS_RUN   = `E3DM_LOS_RUN,
    parameter int AIS_ZEROS = `E3DM_AIS_MAX_ZEROS
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire e3dm_line_t    line_i,
    input  wire e3dm_ext_def_t ext_def,
    input  wire e3dm_ext_evt_t ext_evt,
    output logic [7:0]         op_mode,
    output logic               lof_algo_sel,
    output logic               los_defect,
    output logic               ais_defect,
    output logic               int_n
);
    // ======================================================
    // Declarations
    e3dm_bus_st_t bus_st_r;
    e3dm_sel_t    sel_r;
    logic         size_ok_r;
    logic [31:0]  hrdata_r;
    logic [7:0]   opmode_r;
    logic         lof_algo_r;
    logic [6:0]   istat_r;
    logic [6:0]   istat_nxt;
    logic [6:0]   mask_r;
    logic [6:0]   mask_nxt;
    logic         int_n_r;
    logic         los_d_r;
    logic         ais_d_r;
    logic         addr_take;
    logic         wr_ok;
    logic         rd_now;
    logic [6:0]   set_v;
    logic [6:0]   clr_v;
    logic [7:0]   rd_val;
    logic [7:0]   defect_val;

    // ======================================================
    // Address decode
    function automatic e3dm_sel_t reg_sel(input logic [31:0] a);
        logic [15:0] idx;
        idx = a[17:2];
        if (a[31:18] != '0 || a[1:0] != 2'h0)
            return SEL_NONE;
        unique case (idx)
            `E3DM_IDX_OPMODE: return SEL_OPMODE;
            `E3DM_IDX_DEFECT: return SEL_DEFECT;
            `E3DM_IDX_ISTAT:  return SEL_ISTAT;
            `E3DM_IDX_MASK:   return SEL_MASK;
            default:          return SEL_NONE;
        endcase
    endfunction

    assign addr_take = hsel && htrans[1] && hready;
    assign wr_ok     = bus_st_r == BUS_WR && size_ok_r;
    assign rd_now    = bus_st_r == BUS_RD;

    // ======================================================
    // Bus phase tracking
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_st_r  <= BUS_IDLE;
            sel_r     <= SEL_NONE;
            size_ok_r <= 1'b0;
        end else if (rd_now) begin
            bus_st_r  <= BUS_RDONE;
        end else if (addr_take) begin
            bus_st_r  <= hwrite ? BUS_WR : BUS_RD;
            sel_r     <= reg_sel(haddr);
            size_ok_r <= hsize == `E3DM_HSIZE_WORD;
        end else begin
            bus_st_r  <= BUS_IDLE;
        end
    end

    // One wait state on reads so a write just ahead is seen
    assign hreadyout = bus_st_r != BUS_RD;
    assign hresp     = 1'b0;

    // ======================================================
    // Read data
    assign defect_val = {lof_algo_r,
                         ext_def.lof,
                         ext_def.oof,
                         los_defect,
                         ais_defect,
                         ext_def.payload_label_unstable,
                         ext_def.trail_trace_mismatch_flag,
                         ext_def.ferf};

    always_comb begin
        rd_val = 8'h00;
        unique case (sel_r)
            SEL_NONE:   rd_val = 8'h00;
            SEL_OPMODE: rd_val = opmode_r;
            SEL_DEFECT: rd_val = defect_val;
            SEL_ISTAT:  rd_val = {1'b0, istat_r};
            SEL_MASK:   rd_val = {1'b0, mask_r};
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata_r <= 32'h0000_0000;
        else if (rd_now)
            hrdata_r <= {24'h00_0000, rd_val};
    end

    assign hrdata = hrdata_r;

    // ======================================================
    // Operating mode and defect status control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            opmode_r <= `E3DM_RST_OPMODE;
        else if (wr_ok && sel_r == SEL_OPMODE)
            opmode_r <= hwdata[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            lof_algo_r <= `E3DM_RST_LOF_ALGO;
        else if (wr_ok && sel_r == SEL_DEFECT)
            lof_algo_r <= hwdata[`E3DM_DS_LOF_ALGO];
    end

    assign op_mode      = opmode_r;
    assign lof_algo_sel = lof_algo_r;

    // ======================================================
    // Defect detectors
    e3dm_los_det #(
        .RUN_LEN   (LOS_RUN),
        .CLEAN_RUN (`E3DM_LOS_CLEAN_RUN)
    ) u_los (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .line_i     (line_i),
        .own_on     (opmode_r[`E3DM_OP_OWN_LOS]),
        .los_defect (los_defect)
    );

    e3dm_ais_det #(
        .MAX_ZEROS (AIS_ZEROS)
    ) u_ais (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .line_i     (line_i),
        .e3_mode    (!opmode_r[`E3DM_OP_DS3]),
        .ais_defect (ais_defect)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            los_d_r <= 1'b0;
            ais_d_r <= 1'b0;
        end else begin
            los_d_r <= los_defect;
            ais_d_r <= ais_defect;
        end
    end

    // ======================================================
    // Change flags, set wins over clear
    assign set_v = {ext_evt,
                    los_defect != los_d_r,
                    ais_defect != ais_d_r};

    always_comb begin
        clr_v = 7'h00;
        if (rd_now && sel_r == SEL_ISTAT)
            clr_v = 7'h7f;
        else if (wr_ok && sel_r == SEL_ISTAT)
            clr_v = hwdata[6:0];
        istat_nxt = (istat_r & ~clr_v) | set_v;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            istat_r <= `E3DM_RST_ISTAT;
        else
            istat_r <= istat_nxt;
    end

    // ======================================================
    // Interrupt mask and output
    always_comb begin
        mask_nxt = mask_r;
        if (wr_ok && sel_r == SEL_MASK)
            mask_nxt = hwdata[6:0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            mask_r <= `E3DM_RST_MASK;
        else
            mask_r <= mask_nxt;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            int_n_r <= 1'b1;
        else
            int_n_r <= ~|(istat_nxt & mask_nxt);
    end

    assign int_n = int_n_r;

    // ======================================================
    // Checks
    los_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        los_defect != los_d_r |=> istat_r[`E3DM_IS_LOS]
        && (int_n == !(|(istat_r & mask_r))))
        else $error("loss change did not set its flag");

    los_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(los_defect) && mask_r[`E3DM_IS_LOS]
        && mask_nxt[`E3DM_IS_LOS] |=> ##1 !int_n)
        else $error("loss change did not pull interrupt low");

    ais_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ais_defect != ais_d_r |=> istat_r[`E3DM_IS_AIS])
        else $error("alarm change did not set its flag");

    ais_status_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_now && sel_r == SEL_DEFECT |=>
        hrdata[`E3DM_DS_AIS] == $past(ais_defect)
        && hrdata[`E3DM_DS_LOS] == $past(los_defect))
        else $error("defect status read does not match");

    istat_top_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_now && sel_r == SEL_ISTAT |=> hrdata[31:7] == '0
        && hrdata[6:0] == $past(istat_r))
        else $error("interrupt status read wrong");

    read_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        rd_now && sel_r == SEL_ISTAT && set_v == '0 |=> istat_r == '0)
        else $error("interrupt status not cleared by read");

    lof_algo_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ok && sel_r == SEL_DEFECT |=>
        lof_algo_sel == $past(hwdata[`E3DM_DS_LOF_ALGO]))
        else $error("algorithm select not written");

    own_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_ok && sel_r == SEL_OPMODE |=>
        op_mode[`E3DM_OP_OWN_LOS] == $past(hwdata[`E3DM_OP_OWN_LOS]))
        else $error("own detector enable not written");

    irq_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !int_n && clr_v == '0 && mask_nxt == mask_r |=> !int_n)
        else $error("interrupt released with flags set");

    read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    los_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(los_defect));
    ais_seen_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(ais_defect));
    clear_read_c: cover property (@(posedge hclk) disable iff (!hresetn)
        rd_now && sel_r == SEL_ISTAT && istat_r != '0);
    irq_release_c: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(int_n));
endmodule
`default_nettype wire

// ---- e3dm_line_model.sv ----
// Line side model: framed E3 bit stream and line-unit loss level
// Assumes e3dm_pkg is compiled first; one bit per hclk while running
`timescale 1ns/10ps
`default_nettype none
module e3dm_line_model import e3dm_pkg::*; #(
    parameter int FRAME_LEN = 64
) (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       run,
    input  wire logic       all_zero,
    input  wire logic [7:0] n_zeros,
    input  wire logic       liu_los_in,
    output var e3dm_line_t  line_o
);
    // ==========================================================
    // Bit position in frame, zeros kept isolated
    logic [7:0] pos_r;
    logic       zero_bit;

    assign zero_bit = all_zero || (pos_r < {n_zeros[6:0], 1'b0} && !pos_r[0]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pos_r  <= 8'h00;
            line_o <= '0;
        end else begin
            line_o.liu_los     <= liu_los_in;
            line_o.bit_en      <= run;
            line_o.frame_start <= run && (pos_r == 8'h00);
            if (run) begin
                line_o.bit_val <= !zero_bit;
                pos_r <= (pos_r == 8'(FRAME_LEN - 1)) ? 8'h00 : pos_r + 8'h01;
            end else begin
                // Idle line toggles, never holds the last bit
                line_o.bit_val <= !line_o.bit_val;
            end
        end
    end
endmodule
`default_nettype wire

// ---- e3dm_tb_top.sv ----
// Self-checking testbench for the E3 defect monitor
// Assumes the package, the line model and the design are compiled first
`include "e3dm_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module e3dm_tb_top import e3dm_pkg::*; ;
    // ==========================================================
    // Signals
    logic          hclk, hresetn, hsel, hwrite, run, all_zero, liu_los;
    logic [31:0]   haddr, hwdata;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    logic [7:0]    n_zeros;
    e3dm_ext_def_t ext_def;
    e3dm_ext_evt_t ext_evt;
    e3dm_line_t    line_w;
    wire logic [31:0] hrdata;
    wire logic [7:0]  op_mode;
    wire logic        hreadyout, hresp, lof_algo_sel;
    wire logic        los_defect, ais_defect, int_n;
    int            bad_count, n_compared;

    e3dm_top #(.LOS_RUN(8), .AIS_ZEROS(7)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .line_i(line_w),
        .ext_def(ext_def), .ext_evt(ext_evt), .op_mode(op_mode),
        .lof_algo_sel(lof_algo_sel), .los_defect(los_defect),
        .ais_defect(ais_defect), .int_n(int_n));

    e3dm_line_model #(.FRAME_LEN(64)) line_mdl (
        .hclk(hclk), .hresetn(hresetn), .run(run), .all_zero(all_zero),
        .n_zeros(n_zeros), .liu_los_in(liu_los), .line_o(line_w));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    // ==========================================================
    // Compare, bus and wait tasks
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ahb_wr(input logic [15:0] idx, input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {14'h0, idx, 2'b00};
        hwrite <= 1'b1;
        hsize  <= `E3DM_HSIZE_WORD;
        @(posedge hclk iff hreadyout === 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        @(posedge hclk iff hreadyout === 1'b1);
    endtask

    task automatic rd_chk(input string what, input logic [15:0] idx,
                          input logic [7:0] exp);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {14'h0, idx, 2'b00};
        hwrite <= 1'b0;
        hsize  <= `E3DM_HSIZE_WORD;
        @(posedge hclk iff hreadyout === 1'b1);
        htrans <= 2'b00;
        @(posedge hclk iff hreadyout === 1'b1);
        chk(what, {24'h0, exp}, hrdata);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wait_lvl(input string what, input bit ais, input logic v);
        int i;
        for (i = 0; i < 600; i++) begin
            @(posedge hclk);
            if ((ais ? ais_defect : los_defect) === v) break;
        end
        chk(what, {31'h0, v}, {31'h0, ais ? ais_defect : los_defect});
    endtask

    task automatic irq_chk(input logic [7:0] exp);
        @(posedge hclk);
        chk("int_n", 32'h0, {31'h0, int_n});
        rd_chk("istat", `E3DM_IDX_ISTAT, exp);
        rd_chk("istat", `E3DM_IDX_ISTAT, 8'h00);
        chk("int_n", 32'h1, {31'h0, int_n});
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        bad_count++;
        complete_run();
    end

    // ==========================================================
    // Main sequence
    initial begin
        hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'b00;
        haddr = 32'h0; hwdata = 32'h0; hsize = 3'h2; run = 1'b0;
        all_zero = 1'b0; liu_los = 1'b0; n_zeros = 8'd8;
        ext_def = '0; ext_evt = '0; bad_count = 0; n_compared = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk("opmode", `E3DM_IDX_OPMODE, `E3DM_RST_OPMODE);
        rd_chk("defect", `E3DM_IDX_DEFECT, 8'h00);
        rd_chk("istat", `E3DM_IDX_ISTAT, 8'h00);
        rd_chk("mask", `E3DM_IDX_MASK, 8'h7f);
        rd_chk("unmapped", 16'h1113, 8'h00);
        // Defect status: bit 7 stored, rest live
        ahb_wr(`E3DM_IDX_DEFECT, 8'hff);
        ext_def <= 5'b10101;
        rd_chk("defect", `E3DM_IDX_DEFECT, 8'hc5);
        chk("lof_algo_sel", 32'h1, {31'h0, lof_algo_sel});
        ahb_wr(`E3DM_IDX_DEFECT, 8'h00);
        ext_def <= '0;
        // Masked events, write-one clear, then unmask
        ahb_wr(`E3DM_IDX_MASK, 8'h00);
        ext_evt <= 5'b11000;
        @(posedge hclk);
        ext_evt <= 5'b00111;
        @(posedge hclk);
        ext_evt <= '0;
        repeat (3) @(posedge hclk);
        chk("int_n", 32'h1, {31'h0, int_n});
        ahb_wr(`E3DM_IDX_ISTAT, 8'h84);
        ahb_wr(`E3DM_IDX_MASK, 8'h7f);
        @(posedge hclk);
        irq_chk(8'h78);
        // Own detector off: zeros ignored, line unit decides
        run <= 1'b1;
        all_zero <= 1'b1;
        repeat (40) @(posedge hclk);
        chk("los", 32'h0, {31'h0, los_defect});
        liu_los <= 1'b1;
        wait_lvl("los", 1'b0, 1'b1);
        rd_chk("defect", `E3DM_IDX_DEFECT, 8'h10);
        irq_chk(8'h02);
        liu_los <= 1'b0;
        wait_lvl("los", 1'b0, 1'b0);
        irq_chk(8'h02);
        // Own detector on at bit 5
        ahb_wr(`E3DM_IDX_OPMODE, 8'h2b);
        @(posedge hclk);
        chk("op_mode", 32'h2b, {24'h0, op_mode});
        wait_lvl("los", 1'b0, 1'b1);
        irq_chk(8'h02);
        liu_los <= 1'b1;
        all_zero <= 1'b0;
        repeat (100) @(posedge hclk);
        chk("los", 32'h1, {31'h0, los_defect});
        liu_los <= 1'b0;
        wait_lvl("los", 1'b0, 1'b0);
        irq_chk(8'h02);
        // Alarm indication: eight zeros over two frames is not enough
        n_zeros <= 8'h04;
        repeat (300) @(posedge hclk);
        chk("ais", 32'h0, {31'h0, ais_defect});
        n_zeros <= 8'h03;
        wait_lvl("ais", 1'b1, 1'b1);
        rd_chk("defect", `E3DM_IDX_DEFECT, 8'h08);
        irq_chk(8'h01);
        // Rate select high forces the alarm off, low lets it back
        ahb_wr(`E3DM_IDX_OPMODE, 8'h6b);
        wait_lvl("ais", 1'b1, 1'b0);
        irq_chk(8'h01);
        ahb_wr(`E3DM_IDX_OPMODE, 8'h2b);
        wait_lvl("ais", 1'b1, 1'b1);
        irq_chk(8'h01);
        n_zeros <= 8'h07;
        repeat (300) @(posedge hclk);
        chk("ais", 32'h1, {31'h0, ais_defect});
        n_zeros <= 8'h08;
        wait_lvl("ais", 1'b1, 1'b0);
        irq_chk(8'h01);
        complete_run();
    end
endmodule
`default_nettype wire
